//--- hdl/dmab_pkg.sv
// constants shared by the channel b destination-step and trigger-select block
package dmab_pkg;

	// apb byte offsets, one aligned word per register
	localparam logic [7:0] OFF_CTRL0 = 8'h00;
	localparam logic [7:0] OFF_CTRL1 = 8'h04;
	localparam logic [7:0] OFF_MODE0 = 8'h08;
	localparam logic [7:0] OFF_MODE1 = 8'h0C;
	localparam logic [7:0] OFF_DEST0 = 8'h10;
	localparam logic [7:0] OFF_DEST1 = 8'h14;
	localparam logic [7:0] OFF_STAT  = 8'h18;

	// control byte field positions
	localparam int unsigned CTRL_DIR_BIT = 6;
	localparam int unsigned CTRL_EN_BIT  = 5;

	// mode register field positions
	localparam int unsigned MODE_EN_BIT   = 0;
	localparam int unsigned MODE_BLK_BIT  = 1;
	localparam int unsigned MODE_WORD_BIT = 2;

	// status register field positions
	localparam int unsigned STAT_PEND_LSB  = 0;
	localparam int unsigned STAT_BUSY_LSB  = 2;
	localparam int unsigned STAT_FIRST_LSB = 4;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [2:0] MODE_RST = 3'h0;

	// activation source codes
	localparam logic [3:0] SRC_ADC        = 4'h1;
	localparam logic [3:0] SRC_EXT_FALL   = 4'h2;
	localparam logic [3:0] SRC_EXT_LOW    = 4'h3;
	localparam logic [3:0] SRC_SER0_TX    = 4'h4;
	localparam logic [3:0] SRC_SER1_RX    = 4'h7;
	localparam logic [3:0] SRC_AUTO_STEAL = 4'h6;
	localparam logic [3:0] SRC_AUTO_BURST = 4'h7;
	localparam logic [3:0] SRC_TMR0       = 4'h8;
	localparam logic [3:0] SRC_TMR5       = 4'hD;

	// destination step amounts in address units
	localparam int unsigned STEP_BYTE = 1;
	localparam int unsigned STEP_WORD = 2;

endpackage

//--- hdl/dmab_dest_step.sv
// destination address register of one channel with its per-transfer stepping
`timescale 1ns/1ps
module dmab_dest_step #(
	parameter int unsigned ADDR_W = 24
) (
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	input  wire logic              i_load,
	input  wire logic [ADDR_W-1:0] i_load_val,
	input  wire logic              i_step,
	input  wire logic              i_step_en,
	input  wire logic              i_step_dir,
	input  wire logic              i_word,
	output logic      [ADDR_W-1:0] o_addr
);

	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;

	// step size follows the transfer size bit
	function automatic logic [ADDR_W-1:0] step_amt(input logic word);
		return word ? ADDR_W'(dmab_pkg::STEP_WORD) : ADDR_W'(dmab_pkg::STEP_BYTE);
	endfunction

	// a software load beats a step in the same cycle so a reprogram is never lost
	always_comb
	begin
		addr_d = addr_q;
		if (i_load)
			addr_d = i_load_val;
		else if (i_step && i_step_en && !i_step_dir)
			addr_d = addr_q + step_amt(i_word);
		else if (i_step && i_step_en && i_step_dir)
			addr_d = addr_q - step_amt(i_word);
	end

	// enable low leaves the address fixed whatever the direction bit says
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			addr_q <= '0;
		else
			addr_q <= addr_d;
	end

	assign o_addr = addr_q;

	property p_fixed;
		@(posedge i_clk) disable iff (!i_nrst)
		(!i_load && i_step && !i_step_en) |=> $stable(o_addr);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed address moved");

	property p_inc;
		@(posedge i_clk) disable iff (!i_nrst)
		(!i_load && i_step && i_step_en && !i_step_dir && !i_word)
		|=> (o_addr == $past(o_addr) + ADDR_W'(1));
	endproperty
	a_inc: assert property (p_inc) else $error("byte increment not one");

	property p_inc_word;
		@(posedge i_clk) disable iff (!i_nrst)
		(!i_load && i_step && i_step_en && !i_step_dir && i_word)
		|=> (o_addr == $past(o_addr) + ADDR_W'(2));
	endproperty
	a_inc_word: assert property (p_inc_word) else $error("word increment not two");

	property p_dec_word;
		@(posedge i_clk) disable iff (!i_nrst)
		(!i_load && i_step && i_step_en && i_step_dir && i_word)
		|=> (o_addr == $past(o_addr) - ADDR_W'(2));
	endproperty
	a_dec_word: assert property (p_dec_word) else $error("word decrement not two");

	property p_dec_byte;
		@(posedge i_clk) disable iff (!i_nrst)
		(!i_load && i_step && i_step_en && i_step_dir && !i_word)
		|=> (o_addr == $past(o_addr) - ADDR_W'(1));
	endproperty
	a_dec_byte: assert property (p_dec_byte) else $error("byte decrement not one");

endmodule // dmab_dest_step

//--- hdl/dmab_top.sv
// two-channel b-side control bytes, trigger selection and apb register slave
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module dmab_top #(
	parameter int unsigned ADDR_W = 24
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_nrst,
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [7:0]             i_paddr,
	input  wire logic [31:0]            i_pwdata,
	input  wire logic [3:0]             i_pstrb,
	output logic      [31:0]            o_prdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	input  wire logic [1:0]             i_ext_req_n,
	input  wire logic                   i_adc_end,
	input  wire logic [3:0]             i_ser_evt,
	input  wire logic [5:0]             i_tmr_evt,
	input  wire logic [1:0]             i_xfer_done,
	output logic      [1:0]             o_start,
	output logic      [1:0]             o_burst,
	output logic      [1:0]             o_word,
	output logic      [1:0][ADDR_W-1:0] o_dest_addr
);

	// register state
	logic [1:0][7:0] ctrl_q;
	logic [1:0][7:0] ctrl_d;
	logic [1:0][2:0] mode_q;
	logic [1:0][2:0] mode_d;
	logic [1:0]      dest_load;
	logic [1:0][ADDR_W-1:0] dest_val;

	// apb answer state
	logic        pready_q;
	logic        pready_d;
	logic        pslverr_q;
	logic        pslverr_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;

	// trigger state per channel
	logic [1:0] pend_q;
	logic [1:0] pend_d;
	logic [1:0] busy_q;
	logic [1:0] busy_d;
	logic [1:0] first_q;
	logic [1:0] first_d;
	logic [1:0] start_q;
	logic [1:0] start_d;
	logic [1:0] burst_q;
	logic [1:0] burst_d;
	logic [1:0] ext_prev_n_q;
	logic [1:0] hit;
	logic [1:0] en;

	logic setup;
	logic wr_acc;

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
	                                      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	// map check, shared by the error answer and nothing else writes elsewhere
	function automatic logic mapped(input logic [7:0] a);
		return (a == dmab_pkg::OFF_CTRL0) || (a == dmab_pkg::OFF_CTRL1) ||
		       (a == dmab_pkg::OFF_MODE0) || (a == dmab_pkg::OFF_MODE1) ||
		       (a == dmab_pkg::OFF_DEST0) || (a == dmab_pkg::OFF_DEST1) ||
		       (a == dmab_pkg::OFF_STAT);
	endfunction

	// source decode; prohibited codes never match so a bad setting just stays idle
	function automatic logic src_hit(input logic [3:0] code, input logic blk,
	                                 input logic ext_low, input logic ext_fall,
	                                 input logic first, input logic adc,
	                                 input logic [3:0] ser, input logic [5:0] tmr);
		logic h;
		h = 1'b0;
		if (code == dmab_pkg::SRC_EXT_FALL)
			h = ext_fall || (first && ext_low);
		else if (code == dmab_pkg::SRC_EXT_LOW)
			h = ext_low;
		else if (!blk)
			h = (code == dmab_pkg::SRC_AUTO_STEAL) || (code == dmab_pkg::SRC_AUTO_BURST);
		else if (code == dmab_pkg::SRC_ADC)
			h = adc;
		else if (code >= dmab_pkg::SRC_SER0_TX && code <= dmab_pkg::SRC_SER1_RX)
			h = ser[code[1:0]];
		else if (code >= dmab_pkg::SRC_TMR0 && code <= dmab_pkg::SRC_TMR5)
			h = tmr[code[2:0]];
		return h;
	endfunction

	assign setup  = i_psel && !i_penable;
	assign wr_acc = i_psel && i_penable && pready_q && i_pwrite;

	// register writes land only at the completing access edge
	always_comb
	begin
		ctrl_d    = ctrl_q;
		mode_d    = mode_q;
		dest_load = 2'h0;
		dest_val  = '0;
		for (int c = 0; c < 2; c++)
			dest_val[c] = ADDR_W'(merge(32'(o_dest_addr[c]), i_pwdata, i_pstrb));
		if (wr_acc)
		begin
			case (i_paddr)
				dmab_pkg::OFF_CTRL0: ctrl_d[0] = 8'(merge(32'(ctrl_q[0]), i_pwdata, i_pstrb));
				dmab_pkg::OFF_CTRL1: ctrl_d[1] = 8'(merge(32'(ctrl_q[1]), i_pwdata, i_pstrb));
				dmab_pkg::OFF_MODE0: mode_d[0] = 3'(merge(32'(mode_q[0]), i_pwdata, i_pstrb));
				dmab_pkg::OFF_MODE1: mode_d[1] = 3'(merge(32'(mode_q[1]), i_pwdata, i_pstrb));
				dmab_pkg::OFF_DEST0: dest_load[0] = 1'b1;
				dmab_pkg::OFF_DEST1: dest_load[1] = 1'b1;
				default: ;
			endcase
		end
	end

	// read data is captured in the setup cycle so the access phase answers at once
	always_comb
	begin
		pready_d  = setup;
		pslverr_d = setup && !mapped(i_paddr);
		prdata_d  = 32'h0000_0000;
		if (setup)
		begin
			case (i_paddr)
				dmab_pkg::OFF_CTRL0: prdata_d = 32'(ctrl_q[0]);
				dmab_pkg::OFF_CTRL1: prdata_d = 32'(ctrl_q[1]);
				dmab_pkg::OFF_MODE0: prdata_d = 32'(mode_q[0]);
				dmab_pkg::OFF_MODE1: prdata_d = 32'(mode_q[1]);
				dmab_pkg::OFF_DEST0: prdata_d = 32'(o_dest_addr[0]);
				dmab_pkg::OFF_DEST1: prdata_d = 32'(o_dest_addr[1]);
				dmab_pkg::OFF_STAT:
				begin
					prdata_d[dmab_pkg::STAT_PEND_LSB  +: 2] = pend_q;
					prdata_d[dmab_pkg::STAT_BUSY_LSB  +: 2] = busy_q;
					prdata_d[dmab_pkg::STAT_FIRST_LSB +: 2] = first_q;
				end
				default: ;
			endcase
		end
	end

	// activation: a source hit beats the clear by start, so no event is dropped
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			en[c]  = mode_q[c][dmab_pkg::MODE_EN_BIT];
			hit[c] = src_hit(ctrl_q[c][3:0], mode_q[c][dmab_pkg::MODE_BLK_BIT],
			                 !i_ext_req_n[c], ext_prev_n_q[c] && !i_ext_req_n[c],
			                 first_q[c], i_adc_end, i_ser_evt, i_tmr_evt);
			burst_d[c] = !mode_q[c][dmab_pkg::MODE_BLK_BIT] &&
			             (ctrl_q[c][3:0] == dmab_pkg::SRC_AUTO_BURST);
		end
		// fixed priority, one start per cycle; channel 1 waits while channel 0 is ready
		start_d[0] = en[0] && pend_q[0] && !busy_q[0];
		start_d[1] = en[1] && pend_q[1] && !busy_q[1] && !start_d[0];
		for (int c = 0; c < 2; c++)
		begin
			pend_d[c]  = en[c] && (hit[c] || (pend_q[c] && !start_d[c]));
			busy_d[c]  = en[c] && (start_d[c] || (busy_q[c] && !i_xfer_done[c]));
			// the first request after enabling is taken on a low level; it is used up
			// by the hit itself, so one held low level cannot pend a second request
			first_d[c] = mode_d[c][dmab_pkg::MODE_EN_BIT] &&
			             ((!en[c]) || (first_q[c] && !hit[c]));
		end
	end

	// single register process for all control and answer state
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ctrl_q       <= {2{dmab_pkg::CTRL_RST}};
			mode_q       <= {2{dmab_pkg::MODE_RST}};
			pready_q     <= 1'b0;
			pslverr_q    <= 1'b0;
			prdata_q     <= 32'h0000_0000;
			pend_q       <= 2'h0;
			busy_q       <= 2'h0;
			first_q      <= 2'h0;
			start_q      <= 2'h0;
			burst_q      <= 2'h0;
			ext_prev_n_q <= 2'h3;
		end
		else
		begin
			ctrl_q       <= ctrl_d;
			mode_q       <= mode_d;
			pready_q     <= pready_d;
			pslverr_q    <= pslverr_d;
			prdata_q     <= prdata_d;
			pend_q       <= pend_d;
			busy_q       <= busy_d;
			first_q      <= first_d;
			start_q      <= start_d;
			burst_q      <= burst_d;
			ext_prev_n_q <= i_ext_req_n;
		end
	end

	// destination steppers; the transfer engine reports each finished transfer
	for (genvar c = 0; c < 2; c++)
	begin : g_dest
		dmab_dest_step #(
			.ADDR_W (ADDR_W)
		) u_step (
			.i_clk      (i_clk),
			.i_nrst     (i_nrst),
			.i_load     (dest_load[c]),
			.i_load_val (dest_val[c]),
			.i_step     (i_xfer_done[c]),
			.i_step_en  (ctrl_q[c][dmab_pkg::CTRL_EN_BIT]),
			.i_step_dir (ctrl_q[c][dmab_pkg::CTRL_DIR_BIT]),
			.i_word     (mode_q[c][dmab_pkg::MODE_WORD_BIT]),
			.o_addr     (o_dest_addr[c])
		);
	end

	assign o_prdata  = prdata_q;
	assign o_pready  = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_start   = start_q;
	assign o_burst   = burst_q;
	always_comb
	begin
		for (int c = 0; c < 2; c++)
			o_word[c] = mode_q[c][dmab_pkg::MODE_WORD_BIT];
	end

	property p_prio;
		@(posedge i_clk) disable iff (!i_nrst)
		(en[0] && en[1] && pend_q[0] && pend_q[1] && !busy_q[0] && !busy_q[1])
		|=> (o_start == 2'h1) ##1 (o_start == 2'h2);
	endproperty
	a_prio: assert property (p_prio) else $error("channel 0 not started first");

	property p_ext_low;
		@(posedge i_clk) disable iff (!i_nrst)
		(en[0] && ctrl_q[0][3:0] == dmab_pkg::SRC_EXT_LOW && !i_ext_req_n[0]) |=> pend_q[0];
	endproperty
	a_ext_low: assert property (p_ext_low) else $error("low level request missed");

	property p_ext_fall_only;
		@(posedge i_clk) disable iff (!i_nrst)
		(en[0] && ctrl_q[0][3:0] == dmab_pkg::SRC_EXT_FALL && !first_q[0] && !pend_q[0]
		 && !ext_prev_n_q[0] && !i_ext_req_n[0]) |=> !pend_q[0];
	endproperty
	a_ext_fall_only: assert property (p_ext_fall_only) else $error("held low retriggered");

	property p_auto;
		@(posedge i_clk) disable iff (!i_nrst)
		(en[0] && !mode_q[0][dmab_pkg::MODE_BLK_BIT] && ctrl_q[0][3:0] == dmab_pkg::SRC_AUTO_BURST)
		|=> (pend_q[0] && o_burst[0]);
	endproperty
	a_auto: assert property (p_auto) else $error("burst auto-request missing");

	property p_adc;
		@(posedge i_clk) disable iff (!i_nrst)
		(en[0] && mode_q[0][dmab_pkg::MODE_BLK_BIT] && ctrl_q[0][3:0] == dmab_pkg::SRC_ADC
		 && i_adc_end) |=> pend_q[0] ##[0:4] o_start[0];
	endproperty
	a_adc: assert property (p_adc) else $error("conversion end not taken");

	property p_adc_normal;
		@(posedge i_clk) disable iff (!i_nrst)
		(en[0] && !mode_q[0][dmab_pkg::MODE_BLK_BIT] && ctrl_q[0][3:0] == dmab_pkg::SRC_ADC
		 && !pend_q[0]) |=> !pend_q[0];
	endproperty
	a_adc_normal: assert property (p_adc_normal) else $error("normal mode decoded 0001");

	property p_ser;
		@(posedge i_clk) disable iff (!i_nrst)
		(en[0] && mode_q[0][dmab_pkg::MODE_BLK_BIT] && ctrl_q[0][3:0] == 4'h5 && i_ser_evt[1])
		|=> pend_q[0];
	endproperty
	a_ser: assert property (p_ser) else $error("serial rx0 event missed");

	property p_tmr;
		@(posedge i_clk) disable iff (!i_nrst)
		(en[0] && mode_q[0][dmab_pkg::MODE_BLK_BIT] && ctrl_q[0][3:0] == 4'hA && i_tmr_evt[2])
		|=> pend_q[0];
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer 2 event missed");

endmodule // dmab_top

//--- bench/dmab_src_model.sv
// far-side model: peripheral event lines, request pins and engine done pulses
`timescale 1ns/1ps
module dmab_src_model (
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic [3:0] i_ev_sel,
	input  wire logic       i_ev_go,
	input  wire logic [1:0] i_req_low,
	input  wire logic       i_slow,
	input  wire logic [1:0] i_kick,
	input  wire logic [1:0] i_start,
	output logic            o_adc_end,
	output logic      [3:0] o_ser_evt,
	output logic      [5:0] o_tmr_evt,
	output logic      [1:0] o_ext_req_n,
	output logic      [1:0] o_xfer_done
);
	logic [1:0][3:0] done_sr_q;
	logic [1:0][3:0] done_sr_d;

	// events are one-cycle pulses and idle low; done comes 1 or 4 cycles after start
	always_comb
	begin
		o_adc_end = i_ev_go && (i_ev_sel == 4'h1);
		o_ext_req_n = ~i_req_low;
		for (int k = 0; k < 4; k++)
			o_ser_evt[k] = i_ev_go && (i_ev_sel == 4'(k + 4));
		for (int k = 0; k < 6; k++)
			o_tmr_evt[k] = i_ev_go && (i_ev_sel == 4'(k + 8));
		for (int c = 0; c < 2; c++)
		begin
			done_sr_d[c] = {done_sr_q[c][2:0], i_start[c]};
			o_xfer_done[c] = (i_slow ? done_sr_q[c][3] : done_sr_q[c][0]) | i_kick[c];
		end
	end

	// done delay line
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			done_sr_q <= '0;
		else
			done_sr_q <= done_sr_d;
	end
endmodule // dmab_src_model

//--- bench/dma_chan_b_dest_step_and_trigger_select_test.sv
// self-checking bench: registers, destination stepping, trigger selection
`timescale 1ns/1ps
module dma_chan_b_dest_step_and_trigger_select_test;
	logic             clk, nrst, psel, pen, pwr, pready, pslverr;
	logic             adc, ev_go, slow, err;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic [3:0]       ser, ev_sel;
	logic [5:0]       tmr;
	logic [1:0]       req_n, req_low, kick, done, start, burst, word, first_st;
	logic [1:0][23:0] dest;
	logic [23:0]      st, ex;
	int               errors, samples_checked, cyc, both;
	int               starts [2];

	dmab_top DUT (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_ext_req_n(req_n),
		.i_adc_end(adc), .i_ser_evt(ser), .i_tmr_evt(tmr), .i_xfer_done(done),
		.o_start(start), .o_burst(burst), .o_word(word), .o_dest_addr(dest));

	dmab_src_model partner (.i_clk(clk), .i_nrst(nrst), .i_ev_sel(ev_sel), .i_ev_go(ev_go),
		.i_req_low(req_low), .i_slow(slow), .i_kick(kick), .i_start(start),
		.o_adc_end(adc), .o_ser_evt(ser), .o_tmr_evt(tmr), .o_ext_req_n(req_n),
		.o_xfer_done(done));

	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// start counters, first starter, hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (start[0])
			starts[0]++;
		if (start[1])
			starts[1]++;
		if (start == 2'b11)
			both++;
		if (first_st == 2'b00)
			first_st = start;
		if (cyc > 20000)
		begin
			errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; idle cycle after it keeps strobe edges apart
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic pulse(input logic [3:0] sel);
		ev_sel <= sel;
		ev_go <= 1'b1;
		@(posedge clk);
		ev_go <= 1'b0;
	endtask

	// channel 0: program source and mode, fire one event, see whether it started
	task automatic trig(input logic [3:0] code, input logic blk, input logic [3:0] sel,
		input logic exp);
		wr(dmab_pkg::OFF_CTRL0, {28'h0, code});
		wr(dmab_pkg::OFF_MODE0, {30'h0, blk, 1'b1});
		starts[0] = 0;
		pulse(sel);
		tick(8);
		chk(32'(starts[0] != 0), {31'h0, exp});
		wr(dmab_pkg::OFF_MODE0, 32'h0);
	endtask

	initial
	begin
		nrst = 1'b0;
		{psel, pen, pwr, ev_go, slow} = '0;
		{paddr, pwdata, ev_sel, req_low, kick, first_st} = '0;
		{errors, samples_checked, cyc, both} = '0;
		starts = '{0, 0};
		tick(12);
		nrst <= 1'b1;
		tick(1);
		// reset values, readback, unmapped address
		apb(1'b0, dmab_pkg::OFF_CTRL0, 32'h0);
		chk(rd, {24'h0, dmab_pkg::CTRL_RST});
		wr(dmab_pkg::OFF_CTRL0, 32'h0000006B);
		apb(1'b0, dmab_pkg::OFF_CTRL0, 32'h0);
		chk(rd, 32'h0000006B);
		apb(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		// every step setting at both sizes, from the top of the address range
		for (int i = 0; i < 8; i++)
		begin
			wr(dmab_pkg::OFF_CTRL0, 32'(i[1:0]) << 5);
			wr(dmab_pkg::OFF_MODE0, {29'h0, i[2], 2'b00});
			wr(dmab_pkg::OFF_DEST0, 32'h00FFFFFF);
			kick <= 2'b01;
			@(posedge clk);
			kick <= 2'b00;
			tick(2);
			st = i[2] ? 24'h000002 : 24'h000001;
			ex = (i[1:0] == 2'h1) ? 24'hFFFFFF + st : 24'hFFFFFF;
			ex = (i[1:0] == 2'h3) ? 24'hFFFFFF - st : ex;
			chk(32'(dest[0]), 32'(ex));
			chk(32'(word[0]), 32'(i[2]));
		end
		wr(dmab_pkg::OFF_MODE0, 32'h0);
		// channel 1 word decrement, seen on the output and read back
		wr(dmab_pkg::OFF_CTRL1, 32'h00000060);
		wr(dmab_pkg::OFF_MODE1, 32'h00000004);
		wr(dmab_pkg::OFF_DEST1, 32'h00000010);
		kick <= 2'b10;
		@(posedge clk);
		kick <= 2'b00;
		tick(2);
		chk(32'(dest[1]), 32'h0000000E);
		chk(32'(word[1]), 32'h1);
		apb(1'b0, dmab_pkg::OFF_DEST1, 32'h0);
		chk(rd, 32'h0000000E);
		wr(dmab_pkg::OFF_MODE1, 32'h0);
		// block mode sources; the wrong event must not start
		for (int c = 1; c < 14; c++)
			if (c != 2 && c != 3)
				trig(4'(c), 1'b1, 4'(c), 1'b1);
		trig(4'h4, 1'b1, 4'h5, 1'b0);
		trig(4'hC, 1'b1, 4'hD, 1'b0);
		trig(4'h6, 1'b1, 4'h0, 1'b0);
		// normal mode auto-request, steal then burst
		for (int b = 0; b < 2; b++)
		begin
			wr(dmab_pkg::OFF_CTRL0, 32'h6 + 32'(b));
			wr(dmab_pkg::OFF_MODE0, 32'h1);
			starts[0] = 0;
			tick(10);
			chk(32'(starts[0] > 1), 32'h1);
			chk(32'(burst[0]), 32'(b));
			wr(dmab_pkg::OFF_MODE0, 32'h0);
		end
		// request pin edge mode, slow engine: low at enable, then a fresh fall
		slow <= 1'b1;
		req_low <= 2'b01;
		wr(dmab_pkg::OFF_CTRL0, 32'h2);
		wr(dmab_pkg::OFF_MODE0, 32'h1);
		starts[0] = 0;
		tick(12);
		chk(32'(starts[0]), 32'h1);
		req_low <= 2'b00;
		tick(3);
		req_low <= 2'b01;
		tick(10);
		chk(32'(starts[0]), 32'h2);
		// level mode repeats while low and stops when high
		slow <= 1'b0;
		wr(dmab_pkg::OFF_CTRL0, 32'h3);
		starts[0] = 0;
		tick(10);
		chk(32'(starts[0] > 1), 32'h1);
		req_low <= 2'b00;
		tick(6);
		starts[0] = 0;
		tick(10);
		chk(32'(starts[0]), 32'h0);
		wr(dmab_pkg::OFF_MODE0, 32'h0);
		// both channels on timer 0: channel 0 first, never together
		wr(dmab_pkg::OFF_CTRL0, 32'h8);
		wr(dmab_pkg::OFF_CTRL1, 32'h8);
		wr(dmab_pkg::OFF_MODE0, 32'h3);
		wr(dmab_pkg::OFF_MODE1, 32'h3);
		starts = '{0, 0};
		first_st = 2'b00;
		pulse(4'h8);
		tick(8);
		chk(32'(first_st), 32'h1);
		chk(32'(starts[1]), 32'h1);
		chk(32'(both), 32'h0);
		final_report();
	end
endmodule // dma_chan_b_dest_step_and_trigger_select_test
